// *** src/rcis_core.sv ***
// Fixed 16-bit instruction core with delayed branches, flag and multiplier
// Notes on behaviour
// [RULE1] Every instruction is one 16-bit word fetched per step.
// [RULE2] Basic instructions retire one per clock.
// [RULE3] Internal data is 32 bits; byte and word loads are sign extended.
// [RULE4] Arithmetic immediates are sign extended, logic immediates zero extended.
// [RULE5] Ordinary operations use registers only; memory needs a load first.
// [RULE6] The memory AND does read-modify-write on a byte without a register load.
// [RULE7] Delayed jumps run the following slot instruction before transferring.
// [RULE8] A delayed jump uses the target register value captured before the slot.
// [RULE9] 16x16 multiply takes 2 cycles, 16x16 accumulate takes 2 cycles.
// [RULE10] 32x32 multiply and 32x32 accumulate take 3 cycles each.
// [RULE11] Only compares write the condition flag in the status register.
// [RULE12] Branch on set is taken when flag true, branch on clear when false.
// [RULE13] Greater-equal compare sets flag when register rn >= register rm signed.
// [RULE14] Add leaves the condition flag untouched.
// [RULE15] Equal compare with immediate zero sets flag when tested register is zero.
// [RULE16] Only an 8-bit immediate lives inside the instruction word.
// [RULE17] Word and longword constants load from a PC-relative literal table.
// [RULE18] No absolute addressing; addresses come via registers, accessed indirectly.
// [RULE19] Wide displacements use register zero plus register indexed addressing.
// [RULE20] Literal displacement zero extended, scaled 2 or 4; longword masks PC.
`timescale 1ns/1ns
module rcis_core (
  input wire logic clk,
  input wire logic reset,
  output logic [31:0] imemAddr,
  input wire logic [15:0] imemData,
  output logic dmemReq,
  output logic dmemWe,
  output logic [1:0] dmemSize,
  output logic [31:0] dmemAddr,
  output logic [31:0] dmemWdata,
  input wire logic [31:0] dmemRdata,
  input wire logic dmemAck,
  output logic [31:0] statusRegister,
  output logic instrRetired
);
  rcis_pkg::rcis_state_e st;
  logic [31:0] pc, delayTarget;
  logic [31:0] gpr [rcis_pkg::NUM_GPR];
  logic condFlag, slotPending, mulAcc, mulLong;
  logic [3:0] op, rn, rm, sub, memDest, regAddr;
  logic [7:0] imm8, rmwMask;
  logic [31:0] rnVal, rmVal, r0Val, sImm, zImm, brDisp, seqPc, loadVal;
  logic [1:0] memKind, memSize, mKind, mSize, mulCnt;
  logic [63:0] mulProd, mac;
  logic signed [31:0] prod16;
  logic signed [63:0] prod32;
  logic exRetire, memDone, mulDone, retire;
  logic regWe, flagWe, flagVal, takeBr, setDelay, memStart, mulStart;
  logic [31:0] regData, brPc, dlyPc, mAddr, mData;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign imemAddr = pc;
  assign op = imemData[15:12]; // [RULE1]
  assign rn = imemData[11:8];
  assign rm = imemData[7:4];
  assign sub = imemData[3:0];
  assign imm8 = imemData[7:0]; // [RULE16]
  assign rnVal = gpr[rn];
  assign rmVal = gpr[rm];
  assign r0Val = gpr[0];
  assign sImm = {{24{imm8[7]}}, imm8}; // [RULE4]
  assign zImm = {24'h000000, imm8}; // [RULE4]
  assign brDisp = {{23{imm8[7]}}, imm8, 1'b0};
  assign seqPc = pc + rcis_pkg::PC_STEP;
  assign prod16 = $signed(rnVal[15:0]) * $signed(rmVal[15:0]);
  assign prod32 = $signed(rnVal) * $signed(rmVal);
  assign statusRegister = {31'h00000000, condFlag};
  assign retire = exRetire | memDone | mulDone; // [RULE2]
  assign instrRetired = retire;

  // Narrow loads widen by sign
  always_comb begin
    case (memSize)
      rcis_pkg::SZ_BYTE: loadVal = {{24{dmemRdata[7]}}, dmemRdata[7:0]}; // [RULE3]
      rcis_pkg::SZ_WORD: loadVal = {{16{dmemRdata[15]}}, dmemRdata[15:0]}; // [RULE3]
      default: loadVal = dmemRdata;
    endcase
  end

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  always_comb begin
    exRetire = 1'b0;
    memDone = 1'b0;
    mulDone = 1'b0;
    regWe = 1'b0;
    regAddr = rn;
    regData = 32'h00000000;
    flagWe = 1'b0;
    flagVal = condFlag;
    takeBr = 1'b0;
    brPc = pc + rcis_pkg::PC_REL_BIAS + brDisp;
    setDelay = 1'b0;
    dlyPc = brPc;
    memStart = 1'b0;
    mKind = rcis_pkg::MK_LOAD;
    mAddr = rmVal;
    mSize = rcis_pkg::SZ_LONG;
    mData = rnVal;
    mulStart = 1'b0;
    case (st)
      rcis_pkg::ST_EXEC: begin
        exRetire = 1'b1;
        case (op)
          rcis_pkg::OP_ADD: begin
            regWe = 1'b1; // [RULE5]
            regData = rnVal + rmVal; // [RULE14]
          end
          rcis_pkg::OP_ADD_IMM: begin
            regWe = 1'b1;
            regData = rnVal + sImm; // [RULE4]
          end
          rcis_pkg::OP_LOAD_IMM8: begin
            regWe = 1'b1;
            regData = sImm; // [RULE16]
          end
          rcis_pkg::OP_AND_IMM: begin
            regWe = 1'b1;
            regData = rnVal & zImm; // [RULE4]
          end
          rcis_pkg::OP_COMPARE_GREATER_EQUAL: begin
            flagWe = 1'b1; // [RULE11]
            flagVal = $signed(rnVal) >= $signed(rmVal); // [RULE13]
          end
          rcis_pkg::OP_COMPARE_EQUAL_IMM: begin
            flagWe = 1'b1; // [RULE11]
            flagVal = r0Val == sImm; // [RULE15]
          end
          rcis_pkg::OP_BR_SET: takeBr = condFlag & ~slotPending; // [RULE12]
          rcis_pkg::OP_BR_CLR: takeBr = ~condFlag & ~slotPending; // [RULE12]
          rcis_pkg::OP_JUMP_DLY: setDelay = ~slotPending; // [RULE7]
          rcis_pkg::OP_JUMP_REG: begin
            setDelay = ~slotPending; // [RULE7]
            dlyPc = rnVal; // [RULE8]
          end
          rcis_pkg::OP_LOAD_PCW: begin
            exRetire = 1'b0;
            memStart = 1'b1; // [RULE17]
            mSize = rcis_pkg::SZ_WORD;
            mAddr = pc + rcis_pkg::PC_REL_BIAS + {23'h000000, imm8, 1'b0}; // [RULE20]
          end
          rcis_pkg::OP_LOAD_PCL: begin
            exRetire = 1'b0;
            memStart = 1'b1; // [RULE17]
            mAddr = (pc & rcis_pkg::PC_LONG_MASK) + rcis_pkg::PC_REL_BIAS
                    + {22'h000000, imm8, 2'b00}; // [RULE20]
          end
          rcis_pkg::OP_LDST: begin
            exRetire = 1'b0;
            memStart = 1'b1; // [RULE5]
            mKind = sub[2] ? rcis_pkg::MK_STORE : rcis_pkg::MK_LOAD;
            mSize = sub[1:0];
            // Register indirect only; indexed form adds register zero
            mAddr = sub[3] ? rmVal + r0Val : rmVal; // [RULE18] [RULE19]
          end
          rcis_pkg::OP_MUL: begin
            if (sub == rcis_pkg::MS_READ_LO || sub == rcis_pkg::MS_READ_HI) begin
              regWe = 1'b1;
              regData = sub[0] ? mac[63:32] : mac[31:0];
            end else if (sub[3:2] == 2'b00) begin
              exRetire = 1'b0;
              mulStart = 1'b1;
            end
          end
          rcis_pkg::OP_AND_MEM: begin
            exRetire = 1'b0;
            memStart = 1'b1; // [RULE6]
            mKind = rcis_pkg::MK_RMW;
            mSize = rcis_pkg::SZ_BYTE;
            mAddr = r0Val;
          end
          default: ;
        endcase
      end
      rcis_pkg::ST_MEM: begin
        if (dmemReq && dmemAck && memKind != rcis_pkg::MK_RMW) begin
          memDone = 1'b1;
          regWe = memKind == rcis_pkg::MK_LOAD;
          regAddr = memDest;
          regData = loadVal; // [RULE3]
        end
      end
      rcis_pkg::ST_MUL: mulDone = mulCnt == 2'h0;
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // Program counter and delay slot
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pc <= rcis_pkg::RESET_PC;
      slotPending <= 1'b0;
      delayTarget <= 32'h00000000;
    end else if (retire) begin
      if (takeBr) begin
        pc <= brPc; // [RULE12]
      end else if (setDelay) begin
        // Target frozen now so the slot cannot redirect it
        delayTarget <= dlyPc; // [RULE8]
        slotPending <= 1'b1;
        pc <= seqPc; // [RULE7]
      end else if (slotPending) begin
        slotPending <= 1'b0;
        pc <= delayTarget; // [RULE7]
      end else begin
        pc <= seqPc; // [RULE2]
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file and status flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < rcis_pkg::NUM_GPR; i++) begin
        gpr[i] <= 32'h00000000;
      end
    end else if (regWe) begin
      gpr[regAddr] <= regData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      condFlag <= 1'b0;
    end else if (flagWe) begin
      condFlag <= flagVal; // [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= rcis_pkg::ST_EXEC;
    end else begin
      case (st)
        rcis_pkg::ST_EXEC: begin
          if (memStart) begin
            st <= rcis_pkg::ST_MEM;
          end else if (mulStart) begin
            st <= rcis_pkg::ST_MUL;
          end
        end
        rcis_pkg::ST_MEM: if (memDone) st <= rcis_pkg::ST_EXEC;
        rcis_pkg::ST_MUL: if (mulDone) st <= rcis_pkg::ST_EXEC;
        default: st <= rcis_pkg::ST_EXEC;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data memory port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      dmemReq <= 1'b0;
      dmemWe <= 1'b0;
      dmemSize <= rcis_pkg::SZ_LONG;
      dmemAddr <= 32'h00000000;
      dmemWdata <= 32'h00000000;
      memKind <= rcis_pkg::MK_LOAD;
      memSize <= rcis_pkg::SZ_LONG;
      memDest <= 4'h0;
      rmwMask <= 8'h00;
    end else if (memStart) begin
      dmemReq <= 1'b1;
      dmemWe <= mKind == rcis_pkg::MK_STORE;
      dmemSize <= mSize;
      dmemAddr <= mAddr;
      dmemWdata <= mData;
      memKind <= mKind;
      memSize <= mSize;
      memDest <= rn;
      rmwMask <= imm8;
    end else if (st == rcis_pkg::ST_MEM && dmemReq && dmemAck) begin
      if (memKind == rcis_pkg::MK_RMW) begin
        // Same byte address, write phase of the read-modify-write
        dmemWe <= 1'b1;
        dmemWdata <= {24'h000000, dmemRdata[7:0] & rmwMask}; // [RULE6]
        memKind <= rcis_pkg::MK_STORE;
      end else begin
        dmemReq <= 1'b0;
        dmemWe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Multiplier
  // ----------------------------------------------------------------
  // Product is formed at issue; the count only models the latency
  always_ff @(posedge clk) begin
    if (reset) begin
      mulProd <= 64'h0000000000000000;
      mulAcc <= 1'b0;
      mulLong <= 1'b0;
      mulCnt <= 2'h0;
    end else if (mulStart) begin
      mulProd <= sub[1] ? prod32 : {{32{prod16[31]}}, prod16};
      mulAcc <= sub[0];
      mulLong <= sub[1];
      case (sub)
        rcis_pkg::MS_MUL16: mulCnt <= 2'(rcis_pkg::MUL16_CYC - 2); // [RULE9]
        rcis_pkg::MS_MAC16: mulCnt <= 2'(rcis_pkg::MAC16_CYC - 2); // [RULE9]
        rcis_pkg::MS_MUL32: mulCnt <= 2'(rcis_pkg::MUL32_CYC - 2); // [RULE10]
        default: mulCnt <= 2'(rcis_pkg::MAC32_CYC - 2); // [RULE10]
      endcase
    end else if (st == rcis_pkg::ST_MUL && mulCnt != 2'h0) begin
      mulCnt <= mulCnt - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mac <= 64'h0000000000000000;
    end else if (mulDone) begin
      if (mulAcc) begin
        mac <= mac + mulProd; // [RULE9] [RULE10]
      end else if (mulLong) begin
        mac <= mulProd; // [RULE10]
      end else begin
        mac <= {mac[63:32], mulProd[31:0]}; // [RULE9]
      end
    end
  end
endmodule

// *** src/rcis_pkg.sv ***
// Shared constants, encodings and timing for the 16-bit RISC core
package rcis_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 50000;
  localparam int STATE_TIME_PS = 16000;
  // One basic instruction per core clock; never less than one cycle
  localparam int CYCLES_PER_INSTR = (STATE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MUL16_CYC = 2;
  localparam int MAC16_CYC = 2;
  localparam int MUL32_CYC = 3;
  localparam int MAC32_CYC = 3;
  // ----------------------------------------------------------------
  // Addresses and field layout
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_PC = 32'h00000000;
  localparam logic [31:0] PC_STEP = 32'h00000002;
  localparam logic [31:0] PC_REL_BIAS = 32'h00000004;
  localparam logic [31:0] PC_LONG_MASK = 32'hFFFFFFFC;
  localparam int COND_FLAG_BIT = 0;
  localparam int NUM_GPR = 16;
  // ----------------------------------------------------------------
  // Opcodes in bits 15..12
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_ADD = 4'h1;
  localparam logic [3:0] OP_ADD_IMM = 4'h2;
  localparam logic [3:0] OP_LOAD_IMM8 = 4'h3;
  localparam logic [3:0] OP_AND_IMM = 4'h4;
  localparam logic [3:0] OP_COMPARE_GREATER_EQUAL = 4'h5;
  localparam logic [3:0] OP_COMPARE_EQUAL_IMM = 4'h6;
  localparam logic [3:0] OP_BR_SET = 4'h7;
  localparam logic [3:0] OP_BR_CLR = 4'h8;
  localparam logic [3:0] OP_JUMP_DLY = 4'h9;
  localparam logic [3:0] OP_JUMP_REG = 4'hA;
  localparam logic [3:0] OP_LOAD_PCW = 4'hB;
  localparam logic [3:0] OP_LOAD_PCL = 4'hC;
  localparam logic [3:0] OP_LDST = 4'hD;
  localparam logic [3:0] OP_MUL = 4'hE;
  localparam logic [3:0] OP_AND_MEM = 4'hF;
  // Multiply sub-codes in bits 3..0
  localparam logic [3:0] MS_MUL16 = 4'h0;
  localparam logic [3:0] MS_MAC16 = 4'h1;
  localparam logic [3:0] MS_MUL32 = 4'h2;
  localparam logic [3:0] MS_MAC32 = 4'h3;
  localparam logic [3:0] MS_READ_LO = 4'h4;
  localparam logic [3:0] MS_READ_HI = 4'h5;
  // Access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // Kinds of pending data access
  localparam logic [1:0] MK_LOAD = 2'h0;
  localparam logic [1:0] MK_STORE = 2'h1;
  localparam logic [1:0] MK_RMW = 2'h2;
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_MEM = 2'b01,
    ST_MUL = 2'b10
  } rcis_state_e;
endpackage

// *** verification/rcis_core_chk.sv ***
// Port checker for fetch order, branches, flag, literal loads and latencies
`timescale 1ns/1ns
module rcis_core_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] imemAddr,
  input wire logic [15:0] imemData,
  input wire logic dmemReq,
  input wire logic dmemWe,
  input wire logic [1:0] dmemSize,
  input wire logic [31:0] dmemAddr,
  input wire logic [31:0] dmemWdata,
  input wire logic [31:0] dmemRdata,
  input wire logic dmemAck,
  input wire logic [31:0] statusRegister,
  input wire logic instrRetired
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [3:0] op;
  logic [31:0] relTgt, litL, litW, tgt;
  logic [7:0] rmwW;
  logic brTaken, isMul, inSlot, immSlot;
  logic [2:0] mulCnt;
  assign op = imemData[15:12];
  assign relTgt = imemAddr + 32'h4 + {{23{imemData[7]}}, imemData[7:0], 1'b0};
  assign litL = (imemAddr & rcis_pkg::PC_LONG_MASK) + 32'h4 + {22'h0, imemData[7:0], 2'b00};
  assign litW = imemAddr + 32'h4 + {23'h0, imemData[7:0], 1'b0};
  assign rmwW = dmemRdata[7:0] & imemData[7:0];
  assign brTaken = (op == rcis_pkg::OP_BR_SET) == statusRegister[rcis_pkg::COND_FLAG_BIT];
  assign isMul = op == rcis_pkg::OP_MUL && imemData[3:2] == 2'h0;
  // A jump inside a slot never opens a new slot; the target is held through the slot
  always_ff @(posedge clk) begin
    if (reset) begin
      inSlot <= 1'b0;
    end else if (instrRetired) begin
      inSlot <= !inSlot && (op == rcis_pkg::OP_JUMP_DLY || op == rcis_pkg::OP_JUMP_REG);
      if (!inSlot) begin
        immSlot <= op == rcis_pkg::OP_JUMP_DLY;
        tgt <= relTgt;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset || instrRetired || !isMul) begin
      mulCnt <= 3'h0;
    end else begin
      mulCnt <= mulCnt + 3'h1;
    end
  end
  property p_step;
    !inSlot && instrRetired && op inside {[4'h1:4'h6]} |=> imemAddr == $past(imemAddr) + 32'h2;
  endproperty
  a_step: assert property (p_step) else $error("basic op did not step by one word");
  property p_flag_keep;
    instrRetired && !(op inside {4'h5, 4'h6}) |=> $stable(statusRegister);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag moved");
  property p_slot_first;
    !inSlot && instrRetired && op inside {4'h9, 4'hA} |=> imemAddr == $past(imemAddr) + 32'h2;
  endproperty
  a_slot_first: assert property (p_slot_first) else $error("slot skipped");
  property p_redirect;
    inSlot && immSlot && instrRetired |=> imemAddr == tgt;
  endproperty
  a_redirect: assert property (p_redirect) else $error("wrong jump target");
  property p_br;
    !inSlot && instrRetired && op inside {4'h7, 4'h8}
      |=> imemAddr == ($past(brTaken) ? $past(relTgt) : $past(imemAddr) + 32'h2);
  endproperty
  a_br: assert property (p_br) else $error("conditional branch wrong");
  property p_lit_long;
    !reset && op == rcis_pkg::OP_LOAD_PCL && !dmemReq |=> dmemReq && !dmemWe
      && dmemSize == rcis_pkg::SZ_LONG && dmemAddr == $past(litL);
  endproperty
  a_lit_long: assert property (p_lit_long) else $error("long literal access");
  property p_lit_word;
    !reset && op == rcis_pkg::OP_LOAD_PCW && !dmemReq |=> dmemReq && !dmemWe
      && dmemSize == rcis_pkg::SZ_WORD && dmemAddr == $past(litW);
  endproperty
  a_lit_word: assert property (p_lit_word) else $error("word literal access");
  property p_rmw;
    op == rcis_pkg::OP_AND_MEM && dmemReq && !dmemWe && dmemAck |=> dmemReq && dmemWe
      && $stable(dmemAddr) && dmemWdata[7:0] == $past(rmwW);
  endproperty
  a_rmw: assert property (p_rmw) else $error("memory AND write-back wrong");
  property p_mul_short;
    isMul && !imemData[1] && instrRetired |-> mulCnt == 3'(rcis_pkg::MUL16_CYC - 1);
  endproperty
  a_mul_short: assert property (p_mul_short) else $error("short multiply latency");
  property p_mul_long;
    isMul && imemData[1] && instrRetired |-> mulCnt == 3'(rcis_pkg::MUL32_CYC - 1);
  endproperty
  a_mul_long: assert property (p_mul_long) else $error("long multiply latency");
  c_mul: cover property (isMul && imemData[1] && instrRetired);
  c_rmw: cover property (dmemReq && dmemWe && dmemAck);
  c_taken: cover property (instrRetired && op == rcis_pkg::OP_BR_SET && brTaken);
endmodule
bind rcis_core rcis_core_chk CHK (.clk(clk), .reset(reset), .imemAddr(imemAddr),
  .imemData(imemData), .dmemReq(dmemReq), .dmemWe(dmemWe), .dmemSize(dmemSize),
  .dmemAddr(dmemAddr), .dmemWdata(dmemWdata), .dmemRdata(dmemRdata),
  .dmemAck(dmemAck), .statusRegister(statusRegister), .instrRetired(instrRetired));

// *** verification/rcis_mem_model.sv ***
// Unified little-endian memory for fetch and data, with randomly slow acknowledge
`timescale 1ns/1ns
module rcis_mem_model (
  input wire logic clk,
  input wire logic [31:0] imemAddr,
  output logic [15:0] imemData,
  input wire logic dmemReq,
  input wire logic dmemWe,
  input wire logic [1:0] dmemSize,
  input wire logic [31:0] dmemAddr,
  input wire logic [31:0] dmemWdata,
  output logic [31:0] dmemRdata,
  output logic dmemAck
);
  logic [7:0] mem [0:1023];
  logic [1:0] waitCnt;
  logic gap;
  integer seed = 96;
  initial begin
    dmemAck = 1'b0;
    dmemRdata = 32'h0;
    waitCnt = 2'h0;
    gap = 1'b0;
  end
  // Narrow reads return the whole longword, so upper bits carry the neighbouring bytes unmasked
  function automatic logic [31:0] rd(input logic [31:0] a);
    return {mem[a[9:0] + 10'h3], mem[a[9:0] + 10'h2], mem[a[9:0] + 10'h1], mem[a[9:0]]};
  endfunction
  assign imemData = {mem[imemAddr[9:0] + 10'h1], mem[imemAddr[9:0]]};
  always @(posedge clk) begin
    dmemAck <= 1'b0;
    dmemRdata <= ~dmemRdata;
    // No answer in the cycle after an answer, which keeps the AND write-back honest
    gap <= dmemAck;
    if (dmemReq && !dmemAck && !gap) begin
      if (waitCnt == 2'h0) begin
        dmemAck <= 1'b1;
        dmemRdata <= rd(dmemAddr);
        waitCnt <= 2'($random(seed) & 1);
      end else begin
        waitCnt <= waitCnt - 2'h1;
      end
    end
    if (dmemAck && dmemWe) begin
      for (int k = 0; k < 4; k++) begin
        if (k == 0 || (k == 1 && dmemSize != 2'h0) || dmemSize[1]) begin
          mem[dmemAddr[9:0] + 10'(k)] <= dmemWdata[8 * k +: 8];
        end
      end
    end
  end
endmodule

// *** verification/risc_core_instruction_semantics_tb.sv ***
// Bench that assembles test programs and checks stored results and the flag
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end
module risc_core_instruction_semantics_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] imemAddr, dmemAddr, dmemWdata, dmemRdata, statusRegister;
  logic [15:0] imemData;
  logic dmemReq, dmemWe, dmemAck, instrRetired;
  logic [1:0] dmemSize;
  integer miscompares = 0;
  integer checked = 0;
  integer seed = 96;
  always #25 clk = ~clk;
  rcis_core DUT (.clk(clk), .reset(reset), .imemAddr(imemAddr), .imemData(imemData),
    .dmemReq(dmemReq), .dmemWe(dmemWe), .dmemSize(dmemSize), .dmemAddr(dmemAddr),
    .dmemWdata(dmemWdata), .dmemRdata(dmemRdata), .dmemAck(dmemAck),
    .statusRegister(statusRegister), .instrRetired(instrRetired));
  rcis_mem_model MEM (.clk(clk), .imemAddr(imemAddr), .imemData(imemData),
    .dmemReq(dmemReq), .dmemWe(dmemWe), .dmemSize(dmemSize), .dmemAddr(dmemAddr),
    .dmemWdata(dmemWdata), .dmemRdata(dmemRdata), .dmemAck(dmemAck));
  function automatic logic [31:0] sx8(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction
  function automatic logic [31:0] sx16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction
  task automatic pokeL(input int a, input logic [31:0] v);
    for (int k = 0; k < 4; k++) MEM.mem[a + k] = v[8 * k +: 8];
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic run(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    logic [15:0] w, w2;
    logic [7:0] bv, mk;
    logic g, q;
    logic signed [63:0] m, m3;
    logic [15:0] prog [0:72];
    logic [31:0] ex [0:14];
    logic [31:0] r;
    int i;
    w = 16'($random(seed));
    w2 = 16'($random(seed));
    bv = 8'($random(seed));
    mk = 8'($random(seed));
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    // Literal offsets: long (pc & ~3) + 4 + 4d, word pc + 4 + 2d; stores go to R3 upward
    prog = '{{8'hC3, 8'h3F}, {8'h30, a}, {8'h31, b}, {8'h32, c}, 16'h35FF, 16'h4580,
      16'hD536, 16'h2304, 16'h3600, 16'h2680, 16'hD636, 16'h2304, 16'h5010, 16'h7000,
      16'h2701, 16'h8000, 16'h2801, 16'hD736, 16'h2304, 16'hD836, 16'h2304, 16'h1010,
      16'h7000, 16'h2A01, 16'h6000, 16'h8000, 16'h2901, 16'hDA36, 16'h2304, 16'hD936,
      16'h2304, 16'h9001, 16'h2B01, 16'h2B40, 16'hDB36, 16'h2304, 16'h3C50, 16'hAC00,
      16'h2C10, 16'h2D40, 16'h2D01, 16'hDD36, 16'h2304, 16'hBE57, 16'hDE36, 16'h2304,
      16'hC029, 16'hDF00, 16'hDF36, 16'h2304, 16'h3404, 16'hDF49, 16'hDF36, 16'h2304,
      {8'hF0, mk}, 16'hDF00, 16'hDF36, 16'h2304, 16'hE120, 16'hED04, 16'hDD36, 16'h2304,
      16'hE122, 16'hE123, 16'hE121, 16'hED04, 16'hEE05, 16'hDD36, 16'h2304, 16'hDE36,
      16'h2304, 16'h90FE, 16'h0000};
    for (i = 0; i < 73; i++) pokeL(2 * i, {MEM.mem[2 * i + 3], MEM.mem[2 * i + 2], prog[i]});
    for (i = 0; i < 16; i++) pokeL(32'h200 + 4 * i, 32'hA5A5A5A5);
    pokeL(32'h100, 32'h200);
    pokeL(32'h104, 32'h1F0);
    pokeL(32'h108, {16'h0, w});
    pokeL(32'h1F0, {24'h0, bv});
    pokeL(32'h1F4, {16'h0, w2});
    g = $signed(sx8(a)) >= $signed(sx8(b));
    q = (sx8(a) + sx8(b)) == 32'h0;
    m = $signed(sx8(b)) * $signed(sx8(c));
    m3 = m * 64'sd3;
    ex = '{32'h80, 32'hFFFFFF80, {31'h0, !g}, {31'h0, g}, {31'h0, !g}, {31'h0, q}, 32'h1,
      32'h1, sx16(w), sx8(bv), sx16(w2), sx8(bv & mk), m[31:0], m3[31:0], m3[63:32]};
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 4000 && imemAddr !== 32'h8E; i++) @(posedge clk);
    if (imemAddr !== 32'h8E) begin
      miscompares++;
      $display("[ERR] end address exp %h got %h", 32'h0000008E, imemAddr);
      close_out;
    end
    for (i = 0; i < 15; i++) begin
      r = MEM.rd(32'h200 + 4 * i);
      if (i < 8) `CHK("result", ex[i], r)
      else `CHK("result", ex[i], r)
    end
    `CHK("flag", {31'h0, q}, statusRegister)
  endtask
  initial begin
    run(8'h05, 8'hFB, 8'h7F);
    run(8'h80, 8'h7F, 8'h80);
    for (int k = 0; k < 4; k++) begin
      run(8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    end
    close_out;
  end
endmodule
